/* File: include/ssf_pkg.sv */
// ssf_pkg: shared constants, types and carriers of the store, shift and flag execution unit
package ssf_pkg;

  // ==========================================================================
  // register file and pointers
  localparam int unsigned GPR_COUNT = 32;
  localparam logic [4:0] PTR_BASE = 5'h1a;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] R0_IDX = 5'h00;
  localparam logic [4:0] R1_IDX = 5'h01;

  // ==========================================================================
  // status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================================
  // software register offsets and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_SP_LO = 8'h02;
  localparam logic [7:0] REG_SP_HI = 8'h03;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_GPR_BASE = 8'h20;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;

  // ==========================================================================
  // types
  typedef enum logic [4:0] {
    OP_NOP, OP_INDIRECT_WRITE, OP_INDIRECT_WRITE_INC, OP_INDIRECT_WRITE_DEC,
    OP_DISPLACED_WRITE, OP_DIRECT_WRITE, OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_INC,
    OP_PROGRAM_MEMORY_WRITE, OP_PORT_IN, OP_PORT_OUT, OP_STACK_SAVE, OP_STACK_RESTORE,
    OP_IO_BIT_RAISE, OP_IO_BIT_LOWER, OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_FLAG_BIT_ON,
    OP_FLAG_BIT_OFF, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT
  } ssf_op_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_MEM = 5'h02,
    S_PM1 = 5'h04,
    S_PM2 = 5'h08,
    S_PM_WAIT = 5'h10
  } ssf_state_t;

  typedef enum logic [2:0] {
    SH_LEFT_LOGICAL, SH_RIGHT_LOGICAL, SH_ROTATE_LEFT, SH_ROTATE_RIGHT, SH_RIGHT_ARITH
  } ssf_shift_t;

  typedef struct packed {
    ssf_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bitn;
    logic [1:0] ptr;
    logic [5:0] disp;
    logic [15:0] addr_k;
    logic [5:0] io;
    logic use_r0;
  } ssf_ins_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ssf_dm_req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } ssf_pm_req_t;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] wmask;
    logic [7:0] wdata;
  } ssf_io_req_t;

endpackage

/* File: verilog/ssf_shift_unit.sv */
// ssf_shift_unit: shift and rotate datapath with its flag results
module ssf_shift_unit import ssf_pkg::*; #(
  parameter int unsigned WIDTH = 8
) (
  input ssf_shift_t kind,
  input logic [WIDTH-1:0] value,
  input logic carry_in,
  output logic [WIDTH-1:0] result,
  output logic carry_out,
  output logic zero,
  output logic negative,
  output logic overflow
);

  // ==========================================================================
  // datapath
  always_comb begin
    result = value;
    carry_out = carry_in;
    case (kind)
      SH_LEFT_LOGICAL: begin
        result = {value[WIDTH-2:0], 1'b0}; // [RULE9]
        carry_out = value[WIDTH-1];
      end
      SH_RIGHT_LOGICAL: begin
        result = {1'b0, value[WIDTH-1:1]}; // [RULE10]
        carry_out = value[0];
      end
      SH_ROTATE_LEFT: begin
        result = {value[WIDTH-2:0], carry_in}; // [RULE11]
        carry_out = value[WIDTH-1];
      end
      SH_ROTATE_RIGHT: begin
        result = {carry_in, value[WIDTH-1:1]}; // [RULE12]
        carry_out = value[0];
      end
      SH_RIGHT_ARITH: begin
        result = {value[WIDTH-1], value[WIDTH-1:1]}; // [RULE13]
        carry_out = value[0];
      end
      default: begin
        result = value;
      end
    endcase
  end

  // ==========================================================================
  // flags
  assign zero = (result == '0);
  assign negative = result[WIDTH-1];
  assign overflow = negative ^ carry_out;

endmodule // ssf_shift_unit

/* File: verilog/ssf_exec.sv */
// ssf_exec: execution of stores, program memory access, stack, i/o bit, shift and flag instructions
//
// What this block does
// [RULE1] pre-decrement store: pointer minus one first, then write there; two cycles, flags kept
// [RULE2] post-increment store: write at pointer, then pointer plus one; two cycles, flags kept
// [RULE3] displacement store: write at Y or Z plus q, pointer kept; two cycles
// [RULE4] direct store: write at the immediate address k; two cycles, flags kept
// [RULE5] program memory read: byte at Z into R0 or named register, optional Z+1; three cycles
// [RULE6] stack save and restore: two cycles each, status flags untouched
// [RULE7] i/o bit raise: selected bit of i/o register to one, others kept; two cycles
// [RULE8] i/o bit lower: selected bit of i/o register to zero, others kept; two cycles
// [RULE9] logical left shift: zero into bit 0, updates Z C N V, one cycle
// [RULE10] logical right shift: zero into bit 7, updates Z C N V, one cycle
// [RULE11] rotate left: carry into bit 0, bit 7 into carry, one cycle
// [RULE12] rotate right: carry into bit 7, bit 0 into carry, one cycle
// [RULE13] arithmetic right shift: sign bit kept, updates Z C N V, one cycle
// [RULE14] bit to transfer flag: copy register bit b into T only, one cycle
// [RULE15] transfer flag to bit: copy T into register bit b, flags kept, one cycle
// [RULE16] set and clear overflow flag alone, one cycle
// [RULE17] set and clear signed test flag alone, one cycle
// [RULE18] set half carry flag alone, one cycle
// [RULE19] clear half carry flag alone, one cycle
// [RULE20] program memory write: R1:R0 word to word at Z, lasts until memory is done
// [RULE21] port in and out move one byte in one cycle, flags kept
// [RULE22] carry, negative, zero, transfer and interrupt flags set or cleared alone, one cycle
//
// Chosen here: strobed register access and the address map.
module ssf_exec import ssf_pkg::*; (
  input logic core_clk,
  input logic rstn,
  input logic ce,
  input ssf_ins_t ins,
  input logic ins_valid,
  output logic ins_ready,
  output ssf_dm_req_t dm,
  input logic [7:0] dm_rdata,
  output ssf_pm_req_t pm,
  input logic [15:0] pm_rdata,
  input logic pm_done,
  output ssf_io_req_t io,
  output logic io_re,
  output logic [5:0] io_raddr,
  input logic [7:0] io_rdata,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ==========================================================================
  // state
  logic [7:0] rf_q [GPR_COUNT];
  ssf_state_t state_q, state_d;
  logic [7:0] status_q, status_d;
  logic [15:0] sp_q, sp_d;
  logic run_q;
  ssf_dm_req_t dm_q, dm_d;
  ssf_pm_req_t pm_q, pm_d;
  ssf_io_req_t io_q, io_d;
  ssf_op_t op_q;
  logic [4:0] wb_rd_q;
  logic pm_hi_q;
  logic [7:0] reg_rdata_q;

  logic accept;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] z_val;
  logic [7:0] rd_val, rr_val;
  logic rf_we;
  logic [4:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic ptr_we;
  logic [4:0] ptr_widx;
  logic [15:0] ptr_new;
  logic mem_wr;
  logic [15:0] mem_addr;
  logic gpr_sel;
  ssf_shift_t sh_kind;
  logic [7:0] sh_res;
  logic sh_c, sh_z, sh_n, sh_v;

  // ==========================================================================
  // operand fetch
  assign ins_ready = ce & run_q & (state_q == S_IDLE);
  assign accept = ins_valid & ins_ready;
  assign ptr_lo = PTR_BASE + {2'b00, ins.ptr, 1'b0};
  assign ptr_val = {rf_q[ptr_lo + 5'h1], rf_q[ptr_lo]};
  assign z_val = {rf_q[PTR_Z_LO + 5'h1], rf_q[PTR_Z_LO]};
  assign rd_val = rf_q[ins.rd];
  assign rr_val = rf_q[ins.rr];
  assign gpr_sel = (reg_addr[7:5] == REG_GPR_BASE[7:5]);
  assign io_re = accept & (ins.op == OP_PORT_IN); // [RULE21]
  assign io_raddr = ins.io;
  assign dm = dm_q;
  assign pm = pm_q;
  assign io = io_q;
  assign reg_rdata = reg_rdata_q;

  always_comb begin
    case (ins.op)
      OP_SHIFT_RIGHT_LOGICAL: sh_kind = SH_RIGHT_LOGICAL;
      OP_ROTATE_LEFT_CARRY: sh_kind = SH_ROTATE_LEFT;
      OP_ROTATE_RIGHT_CARRY: sh_kind = SH_ROTATE_RIGHT;
      OP_SHIFT_RIGHT_ARITH: sh_kind = SH_RIGHT_ARITH;
      default: sh_kind = SH_LEFT_LOGICAL;
    endcase
  end

  ssf_shift_unit #(.WIDTH(8)) u_shift (
    .kind(sh_kind),
    .value(rd_val),
    .carry_in(status_q[FLAG_C]),
    .result(sh_res),
    .carry_out(sh_c),
    .zero(sh_z),
    .negative(sh_n),
    .overflow(sh_v)
  );

  // ==========================================================================
  // execute
  always_comb begin
    state_d = state_q;
    rf_we = 1'b0;
    rf_waddr = ins.rd;
    rf_wdata = 8'h00;
    ptr_we = 1'b0;
    ptr_widx = ptr_lo;
    ptr_new = ptr_val;
    mem_wr = 1'b0;
    mem_addr = ptr_val;
    status_d = status_q;
    sp_d = sp_q;
    dm_d = dm_q;
    dm_d.we = 1'b0;
    dm_d.re = 1'b0;
    pm_d = pm_q;
    pm_d.re = 1'b0;
    pm_d.we = 1'b0;
    io_d = io_q;
    io_d.we = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (accept) begin
          case (ins.op)
            OP_INDIRECT_WRITE: mem_wr = 1'b1;
            OP_INDIRECT_WRITE_INC: begin
              mem_wr = 1'b1; // [RULE2]
              ptr_we = 1'b1;
              ptr_new = ptr_val + 16'h1;
            end
            OP_INDIRECT_WRITE_DEC: begin
              mem_wr = 1'b1; // [RULE1]
              ptr_we = 1'b1;
              ptr_new = ptr_val - 16'h1;
              mem_addr = ptr_val - 16'h1;
            end
            OP_DISPLACED_WRITE: begin
              mem_wr = 1'b1; // [RULE3]
              mem_addr = ptr_val + {10'h000, ins.disp};
            end
            OP_DIRECT_WRITE: begin
              mem_wr = 1'b1; // [RULE4]
              mem_addr = ins.addr_k;
            end
            OP_STACK_SAVE: begin
              mem_wr = 1'b1; // [RULE6]
              mem_addr = sp_q;
              sp_d = sp_q - 16'h1;
            end
            OP_STACK_RESTORE: begin
              sp_d = sp_q + 16'h1; // [RULE6]
              dm_d.re = 1'b1;
              dm_d.addr = sp_q + 16'h1;
              state_d = S_MEM;
            end
            OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_INC: begin
              pm_d.re = 1'b1; // [RULE5]
              pm_d.addr = z_val[15:1];
              state_d = S_PM1;
              ptr_widx = PTR_Z_LO;
              ptr_new = z_val + 16'h1;
              ptr_we = (ins.op == OP_PROGRAM_MEMORY_READ_INC);
            end
            OP_PROGRAM_MEMORY_WRITE: begin
              pm_d.we = 1'b1; // [RULE20]
              pm_d.addr = z_val[15:1];
              pm_d.wdata = {rf_q[R1_IDX], rf_q[R0_IDX]};
              state_d = S_PM_WAIT;
            end
            OP_PORT_IN: begin
              rf_we = 1'b1; // [RULE21]
              rf_wdata = io_rdata;
            end
            OP_PORT_OUT: begin
              io_d.we = 1'b1; // [RULE21]
              io_d.addr = ins.io;
              io_d.wmask = 8'hff;
              io_d.wdata = rr_val;
            end
            OP_IO_BIT_RAISE, OP_IO_BIT_LOWER: begin
              io_d.we = 1'b1;
              io_d.addr = ins.io;
              io_d.wmask = 8'h01 << ins.bitn;
              io_d.wdata = (ins.op == OP_IO_BIT_RAISE) ? (8'h01 << ins.bitn) : 8'h00; // [RULE7] [RULE8]
              state_d = S_MEM;
            end
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
            OP_SHIFT_RIGHT_ARITH: begin
              rf_we = 1'b1; // [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]
              rf_wdata = sh_res;
              status_d[FLAG_C] = sh_c;
              status_d[FLAG_Z] = sh_z;
              status_d[FLAG_N] = sh_n;
              status_d[FLAG_V] = sh_v;
            end
            OP_FLAG_BIT_ON: status_d[ins.bitn] = 1'b1; // [RULE16] [RULE17] [RULE18] [RULE22]
            OP_FLAG_BIT_OFF: status_d[ins.bitn] = 1'b0; // [RULE16] [RULE17] [RULE19] [RULE22]
            OP_BIT_TO_TRANSFER_FLAG: status_d[FLAG_T] = rr_val[ins.bitn]; // [RULE14]
            OP_TRANSFER_FLAG_TO_BIT: begin
              rf_we = 1'b1; // [RULE15]
              rf_wdata = rd_val;
              rf_wdata[ins.bitn] = status_q[FLAG_T];
            end
            default: begin
              state_d = S_IDLE;
            end
          endcase
          if (mem_wr) begin
            dm_d.we = 1'b1;
            dm_d.addr = mem_addr;
            dm_d.wdata = rr_val;
            state_d = S_MEM;
          end
        end
      end
      S_MEM: begin
        state_d = S_IDLE;
        rf_waddr = wb_rd_q;
        rf_wdata = dm_rdata;
        rf_we = (op_q == OP_STACK_RESTORE); // [RULE6]
      end
      S_PM1: state_d = S_PM2;
      S_PM2: begin
        state_d = S_IDLE; // [RULE5]
        rf_we = 1'b1;
        rf_waddr = wb_rd_q;
        rf_wdata = pm_hi_q ? pm_rdata[15:8] : pm_rdata[7:0];
      end
      S_PM_WAIT: begin
        if (pm_done) begin
          state_d = S_IDLE; // [RULE20]
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ==========================================================================
  // sequencing
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= S_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      op_q <= OP_NOP;
      wb_rd_q <= R0_IDX;
      pm_hi_q <= 1'b0;
    end else if (ce && accept) begin
      op_q <= ins.op;
      wb_rd_q <= ins.use_r0 ? R0_IDX : ins.rd; // [RULE5]
      pm_hi_q <= z_val[0];
    end
  end

  // ==========================================================================
  // memory and i/o requests
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dm_q <= '0;
      pm_q <= '0;
      io_q <= '0;
    end else if (ce) begin
      dm_q <= dm_d;
      pm_q <= pm_d;
      io_q <= io_d;
    end
  end

  // ==========================================================================
  // general registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < GPR_COUNT; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else if (ce) begin
      if (reg_wr && gpr_sel) begin
        rf_q[reg_addr[4:0]] <= reg_wdata;
      end
      if (ptr_we) begin
        rf_q[ptr_widx] <= ptr_new[7:0]; // [RULE1] [RULE2]
        rf_q[ptr_widx + 5'h1] <= ptr_new[15:8];
      end
      if (rf_we) begin
        rf_q[rf_waddr] <= rf_wdata;
      end
    end
  end

  // ==========================================================================
  // status register, stack pointer, control
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status_q <= STATUS_RESET;
    end else if (ce) begin
      if (accept) begin
        status_q <= status_d;
      end else if (reg_wr && reg_addr == REG_STATUS) begin
        status_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sp_q <= SP_RESET;
    end else if (ce) begin
      if (accept) begin
        sp_q <= sp_d;
      end else if (reg_wr && reg_addr == REG_SP_LO) begin
        sp_q[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_SP_HI) begin
        sp_q[15:8] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_q <= CTRL_RESET;
    end else if (ce && reg_wr && reg_addr == REG_CTRL) begin
      run_q <= reg_wdata[0];
    end
  end

  // ==========================================================================
  // register read port
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      reg_rdata_q <= 8'h00;
      if (reg_rd) begin
        if (gpr_sel) begin
          reg_rdata_q <= rf_q[reg_addr[4:0]];
        end else begin
          case (reg_addr)
            REG_CTRL: reg_rdata_q <= {7'h00, run_q};
            REG_STATUS: reg_rdata_q <= status_q;
            REG_SP_LO: reg_rdata_q <= sp_q[7:0];
            REG_SP_HI: reg_rdata_q <= sp_q[15:8];
            REG_STAT: reg_rdata_q <= {3'h0, state_q};
            default: reg_rdata_q <= 8'h00;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // assertions
  sequence s_pm_read_steps;
    state_q == S_PM1 && pm.re ##1 state_q == S_PM2 && !pm.re ##1 state_q == S_IDLE;
  endsequence

  property p_predec_store;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_INDIRECT_WRITE_DEC |=> dm.we && dm.addr == $past(ptr_val) - 16'h1 ##1 !dm.we;
  endproperty
  a_predec_store: assert property (p_predec_store) else $error("pre-decrement store address wrong"); // [RULE1]

  property p_postinc_store;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_INDIRECT_WRITE_INC |=> dm.we && dm.addr == $past(ptr_val) && status_q == $past(status_q);
  endproperty
  a_postinc_store: assert property (p_postinc_store) else $error("post-increment store wrong"); // [RULE2]

  property p_disp_store;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_DISPLACED_WRITE |=> dm.we && dm.addr == $past(ptr_val) + {10'h000, $past(ins.disp)};
  endproperty
  a_disp_store: assert property (p_disp_store) else $error("displacement store address wrong"); // [RULE3]

  property p_direct_store;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_DIRECT_WRITE |=> dm.we && dm.addr == $past(ins.addr_k) && !ins_ready;
  endproperty
  a_direct_store: assert property (p_direct_store) else $error("direct store wrong"); // [RULE4]

  property p_pm_read;
    @(posedge core_clk) disable iff (!rstn)
    accept && (ins.op == OP_PROGRAM_MEMORY_READ || ins.op == OP_PROGRAM_MEMORY_READ_INC) |=> s_pm_read_steps;
  endproperty
  a_pm_read: assert property (p_pm_read) else $error("program memory read not three cycles"); // [RULE5]

  property p_stack_flags;
    @(posedge core_clk) disable iff (!rstn)
    accept && (ins.op == OP_STACK_SAVE || ins.op == OP_STACK_RESTORE) |=> state_q == S_MEM ##1
      state_q == S_IDLE && status_q == $past(status_q, 2);
  endproperty
  a_stack_flags: assert property (p_stack_flags) else $error("stack access timing or flags wrong"); // [RULE6]

  property p_io_raise;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_IO_BIT_RAISE |=> io.we && io.wmask == (8'h01 << $past(ins.bitn)) && io.wdata == io.wmask;
  endproperty
  a_io_raise: assert property (p_io_raise) else $error("i/o bit raise wrong"); // [RULE7]

  property p_io_lower;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_IO_BIT_LOWER |=> io.we && io.wmask == (8'h01 << $past(ins.bitn)) && io.wdata == 8'h00;
  endproperty
  a_io_lower: assert property (p_io_lower) else $error("i/o bit lower wrong"); // [RULE8]

  property p_shl_carry;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_SHIFT_LEFT_LOGICAL |=> status_q[FLAG_C] == $past(rd_val[7]) && !rf_q[$past(ins.rd)][0];
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("left shift result wrong"); // [RULE9]

  property p_bit_to_t;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_BIT_TO_TRANSFER_FLAG |=> status_q[FLAG_T] == $past(rr_val[ins.bitn]) &&
      status_q[5:0] == $past(status_q[5:0]);
  endproperty
  a_bit_to_t: assert property (p_bit_to_t) else $error("transfer flag copy wrong"); // [RULE14]

  property p_flag_on;
    @(posedge core_clk) disable iff (!rstn)
    accept && ins.op == OP_FLAG_BIT_ON |=> status_q == ($past(status_q) | (8'h01 << $past(ins.bitn)));
  endproperty
  a_flag_on: assert property (p_flag_on) else $error("flag set touched other bits"); // [RULE16] [RULE18] [RULE22]

endmodule // ssf_exec

/* File: verification/ssf_mem_model.sv */
// ssf_mem_model: data memory, program memory and i/o registers facing the execution unit
module ssf_mem_model import ssf_pkg::*; (
  input logic core_clk,
  input ssf_dm_req_t dm,
  output logic [7:0] dm_rdata,
  input ssf_pm_req_t pm,
  output logic [15:0] pm_rdata,
  output logic pm_done,
  input ssf_io_req_t io,
  input logic io_re,
  input logic [5:0] io_raddr,
  output logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // storage
  logic [7:0] dmem [0:511];
  logic [15:0] pmem [0:15];
  logic [7:0] iomem [0:63];
  logic [15:0] pm_q = 16'h0000;
  logic pm_re_q = 1'b0;
  initial begin
    pm_done = 1'b0;
    foreach (dmem[i]) dmem[i] = 8'h00;
    foreach (iomem[i]) iomem[i] = 8'h00;
    foreach (pmem[i]) pmem[i] = 16'h0000;
    pmem[8] = 16'h5aa5;
    iomem[5] = 8'h0f;
  end
  // unselected read lines show the inverse
  assign dm_rdata = dm.re ? dmem[dm.addr[8:0]] : ~dmem[dm.addr[8:0]];
  assign io_rdata = io_re ? iomem[io_raddr] : ~iomem[io_raddr];
  assign pm_rdata = pm_re_q ? pm_q : ~pm_q;
  always @(posedge core_clk) begin
    if (dm.we) dmem[dm.addr[8:0]] <= dm.wdata;
    if (io.we) iomem[io.addr] <= (iomem[io.addr] & ~io.wmask) | (io.wdata & io.wmask);
    pm_re_q <= pm.re;
    if (pm.re) pm_q <= pmem[pm.addr[3:0]];
    if (pm.we) pmem[pm.addr[3:0]] <= pm.wdata;
    pm_done <= pm.we;
  end
endmodule // ssf_mem_model

/* File: verification/ssf_exec_bench.sv */
// ssf_exec_bench: self-checking bench of the execution unit
module ssf_exec_bench import ssf_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, ce, ins_valid, ins_ready, pm_done, io_re, reg_wr, reg_rd;
  ssf_ins_t ins;
  ssf_dm_req_t dm;
  ssf_pm_req_t pm;
  ssf_io_req_t io;
  logic [7:0] dm_rdata, io_rdata, reg_addr, reg_wdata, reg_rdata;
  logic [15:0] pm_rdata;
  logic [5:0] io_raddr;
  int err_count = 0;
  int check_count = 0;
  ssf_exec uut (.core_clk, .rstn, .ce, .ins, .ins_valid, .ins_ready, .dm, .dm_rdata, .pm, .pm_rdata,
    .pm_done, .io, .io_re, .io_raddr, .io_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  ssf_mem_model mem (.core_clk, .dm, .dm_rdata, .pm, .pm_rdata, .pm_done, .io, .io_re, .io_raddr, .io_rdata);
  always #5 core_clk = ~core_clk;
  // ==========================================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  function automatic logic [7:0] g(input int n);
    return REG_GPR_BASE + 8'(n);
  endfunction
  function automatic ssf_ins_t mk(input ssf_op_t op, input int d, input int r, input int b, input int p,
                                  input logic [15:0] k);
    ssf_ins_t i;
    i = '0;
    i.op = op;
    i.rd = 5'(d);
    i.rr = 5'(r);
    i.bitn = 3'(b);
    i.ptr = 2'(p);
    i.disp = k[5:0];
    i.addr_k = k;
    i.io = k[5:0];
    i.use_r0 = b[0];
    return i;
  endfunction
  // issue one instruction and count the cycles it holds the port busy
  task automatic run(input ssf_ins_t i, input int busy);
    int n;
    n = 0;
    @(posedge core_clk);
    ins <= i;
    ins_valid <= 1'b1;
    @(posedge core_clk);
    ins_valid <= 1'b0;
    #1;
    while (ins_ready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(busy));
  endtask
  function automatic logic [11:0] shx(input int k, input logic [7:0] v, input logic c);
    logic [7:0] r;
    logic co;
    case (k)
      0: {co, r} = {v, 1'b0};
      1: {r, co} = {1'b0, v};
      2: {co, r} = {v, c};
      3: {r, co} = {c, v};
      default: {r, co} = {v[7], v};
    endcase
    return {r[7] ^ co, r[7], r == 8'h00, co, r};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_store;
    wr(g(5), 8'ha5);
    wr(g(29), 8'h01);
    wr(REG_STATUS, 8'h5a);
    run(mk(OP_INDIRECT_WRITE_DEC, 0, 5, 0, 1, 0), 1);
    chk(mem.dmem[9'h0ff], 8'ha5);
    rd(g(29), 8'h00);
    wr(g(30), 8'h10);
    run(mk(OP_INDIRECT_WRITE_INC, 0, 5, 0, 2, 0), 1);
    chk(mem.dmem[9'h010], 8'ha5);
    rd(g(30), 8'h11);
    run(mk(OP_DISPLACED_WRITE, 0, 5, 0, 1, 16'h0002), 1);
    chk(mem.dmem[9'h101], 8'ha5);
    rd(g(28), 8'hff);
    run(mk(OP_DIRECT_WRITE, 0, 5, 0, 0, 16'h0040), 1);
    chk(mem.dmem[9'h040], 8'ha5);
    rd(REG_STATUS, 8'h5a);
  endtask
  task automatic t_prog;
    run(mk(OP_PROGRAM_MEMORY_READ, 0, 0, 1, 2, 0), 2);
    rd(g(0), 8'h5a);
    run(mk(OP_PROGRAM_MEMORY_READ_INC, 7, 0, 0, 2, 0), 2);
    rd(g(7), 8'h5a);
    rd(g(30), 8'h12);
    wr(g(0), 8'h34);
    wr(g(1), 8'h12);
    run(mk(OP_PROGRAM_MEMORY_WRITE, 0, 0, 0, 2, 0), 2);
    chk(mem.pmem[9], 16'h1234);
  endtask
  task automatic t_stack_io;
    run(mk(OP_STACK_SAVE, 0, 5, 0, 0, 0), 1);
    rd(REG_SP_HI, 8'hff);
    run(mk(OP_STACK_RESTORE, 8, 0, 0, 0, 0), 1);
    rd(g(8), 8'ha5);
    run(mk(OP_IO_BIT_RAISE, 0, 0, 7, 0, 16'h0005), 1);
    chk(mem.iomem[5], 8'h8f);
    run(mk(OP_IO_BIT_LOWER, 0, 0, 0, 0, 16'h0005), 1);
    chk(mem.iomem[5], 8'h8e);
    run(mk(OP_PORT_OUT, 0, 5, 0, 0, 16'h0009), 0);
    run(mk(OP_PORT_IN, 12, 0, 0, 0, 16'h0009), 0);
    rd(g(12), 8'ha5);
    rd(REG_STATUS, 8'h5a);
  endtask
  task automatic t_shift;
    logic [7:0] v;
    logic [11:0] e;
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 2; j++) begin
        v = j ? 8'h01 : 8'h81;
        e = shx(k, v, ~v[7]);
        wr(g(10), v);
        wr(REG_STATUS, {7'h78, ~v[7]});
        run(mk(ssf_op_t'(OP_SHIFT_LEFT_LOGICAL + k), 10, 10, 0, 0, 0), 0);
        rd(g(10), e[7:0]);
        rd(REG_STATUS, {4'hf, e[11:8]});
      end
    end
  endtask
  task automatic t_flag;
    logic [7:0] m;
    m = 8'h00;
    wr(g(10), 8'h20);
    wr(REG_STATUS, 8'h00);
    run(mk(OP_BIT_TO_TRANSFER_FLAG, 10, 10, 5, 0, 0), 0);
    rd(REG_STATUS, 8'h40);
    run(mk(OP_TRANSFER_FLAG_TO_BIT, 11, 11, 3, 0, 0), 0);
    rd(g(11), 8'h08);
    wr(REG_STATUS, 8'h00);
    for (int s = 0; s < 16; s++) begin
      m[s % 8] = s < 8;
      run(mk(s < 8 ? OP_FLAG_BIT_ON : OP_FLAG_BIT_OFF, 0, 0, s % 8, 0, 0), 0);
      rd(REG_STATUS, m);
    end
  endtask
  // run bit and clock enable hold the unit
  task automatic t_hold;
    wr(REG_CTRL, 8'h00);
    #1 chk(16'(ins_ready), 16'h0000);
    rd(REG_STAT, 8'h01);
    wr(REG_CTRL, 8'h01);
    ce <= 1'b0;
    #1 chk(16'(ins_ready), 16'h0000);
    wr(g(3), 8'h77);
    ce <= 1'b1;
    #1 chk(16'(ins_ready), 16'h0001);
    rd(g(3), 8'h00);
  endtask
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    ins = '0;
    ins_valid = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    t_store;
    t_prog;
    t_stack_io;
    t_shift;
    t_flag;
    t_hold;
    tally_and_finish;
  end
  initial begin
    #100us;
    err_count++;
    tally_and_finish;
  end
endmodule // ssf_exec_bench
